/* File: hw/pte_encoder.sv */
// telegram encoder: pad sampling, mode control, framing, apb registers
`timescale 1ns/1ns
module pte_encoder #(
    parameter int ID_WIDTH = 32
) (
    ref_clk,
    rst_n,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    harvester_input_one,
    harvester_input_two,
    rocker_a_off_input_n,
    rocker_a_on_input_n,
    rocker_b_off_input_n,
    rocker_b_on_input_n,
    securePad,
    standardPad,
    learnButtonPressed,
    contactClosed,
    telegramBytes,
    telegramStrobe,
    telegramKind,
    teachCounter,
    secureActive
);
    input wire logic ref_clk;
    input wire logic rst_n;
    input wire logic psel;
    input wire logic penable;
    input wire logic pwrite;
    input wire logic [7:0] paddr;
    input wire logic [31:0] pwdata;
    output logic [31:0] prdata;
    output logic pready;
    output logic pslverr;
    input wire logic harvester_input_one;
    input wire logic harvester_input_two;
    input wire logic rocker_a_off_input_n;
    input wire logic rocker_a_on_input_n;
    input wire logic rocker_b_off_input_n;
    input wire logic rocker_b_on_input_n;
    input wire logic securePad;
    input wire logic standardPad;
    input wire logic learnButtonPressed;
    input wire logic contactClosed;
    output logic [55:0] telegramBytes;
    output logic telegramStrobe;
    output pte_pkg::pte_kind_type telegramKind;
    output logic [31:0] teachCounter;
    output logic secureActive;

    if (ID_WIDTH != 32) begin : g_bad_width
        $error("pte_encoder: identifier must be 32 bits");
    end

    // every pad is asynchronous to ref_clk; the harvester, rocker, strap,
    // learn and contact levels all take the same two-stage path so that
    // they line up with the pulse event in one and the same cycle.
    // limitation: a pad that moves within two edges of the pulse edge
    // may be seen either way; the straps and buttons are expected to
    // settle well before the harvester fires.
    // pad synchronisers, two stages, first stage read only by the second
    logic [pte_pkg::SYNC_WIDTH-1:0] padRaw;
    logic [pte_pkg::SYNC_WIDTH-1:0] syncOne_reg;
    logic [pte_pkg::SYNC_WIDTH-1:0] syncTwo_reg;
    assign padRaw = {contactClosed, learnButtonPressed, standardPad,
        securePad, rocker_b_on_input_n, rocker_b_off_input_n,
        rocker_a_on_input_n, rocker_a_off_input_n,
        harvester_input_one ^ harvester_input_two};

    genvar gi;
    for (gi = 0; gi < pte_pkg::SYNC_WIDTH; gi++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                syncOne_reg[gi] <= 1'b0;
                syncTwo_reg[gi] <= 1'b0;
            end else begin
                syncOne_reg[gi] <= padRaw[gi];
                syncTwo_reg[gi] <= syncOne_reg[gi];
            end
        end
    end

    // polarity comes from a separately synchronised copy of input two
    logic polOne_reg;
    logic polTwo_reg;
    logic energized_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            polOne_reg <= 1'b0;
            polTwo_reg <= 1'b0;
            energized_reg <= 1'b0;
        end else begin
            polOne_reg <= harvester_input_two;
            polTwo_reg <= polOne_reg;
            energized_reg <= syncTwo_reg[0];
        end
    end

    // one pulse event per rising edge of the harvester difference
    logic pulseEvent;
    assign pulseEvent = syncTwo_reg[0] & ~energized_reg;

    // rocker pads have pull-ups: a pressed button reads low
    logic [3:0] pressed;
    assign pressed = ~syncTwo_reg[4:1];
    logic polarity;
    assign polarity = polTwo_reg;
    logic secureStrap;
    logic standardStrap;
    logic learnLevel;
    logic contactLevel;
    assign secureStrap = syncTwo_reg[5];
    assign standardStrap = syncTwo_reg[6];
    assign learnLevel = syncTwo_reg[7];
    assign contactLevel = syncTwo_reg[8];

    // index order: 0 a off, 1 a on, 2 b off, 3 b on.
    // only the lowest and the highest pressed indices are kept; with three or four
    // presses the multi-press class carries the count instead.
    // press count and the lowest and highest pressed button indices
    logic [2:0] pressCount;
    logic [1:0] firstIdx;
    logic [1:0] secondIdx;
    logic foundFirst;
    always_comb begin
        pressCount = 3'h0;
        firstIdx = 2'h0;
        secondIdx = 2'h0;
        foundFirst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (pressed[i]) begin
                pressCount = pressCount + 3'h1;
                if (!foundFirst) begin
                    firstIdx = i[1:0];
                    foundFirst = 1'b1;
                end else begin
                    secondIdx = i[1:0];
                end
            end
        end
    end

    // registers
    logic [1:0] ctrl_reg;
    logic [31:0] id_reg;
    logic [31:0] key_reg;
    logic [31:0] counter_reg;
    pte_pkg::pte_mode_type mode_reg;
    logic teachPending_reg;

    logic pairClass;
    assign pairClass = (pressCount == 3'h1) || (pressCount == 3'h2);

    // button-pair data: first id, polarity, second id, second valid
    logic [7:0] pairData;
    assign pairData = {1'b0, firstIdx, polarity, 1'b0, secondIdx,
        pressCount[1]};

    logic [2:0] countCode;
    assign countCode = (pressCount == 3'h3) ? pte_pkg::COUNT_THREE :
        (pressCount == 3'h4) ? pte_pkg::COUNT_FOUR :
        pte_pkg::COUNT_NONE;
    logic [7:0] multiData;
    assign multiData = {countCode, polarity, 4'h0};

    logic [7:0] rockerData;
    assign rockerData = pairClass ? pairData : multiData;
    logic [7:0] rockerStatus;
    assign rockerStatus = {pte_pkg::STATUS_RESERVED, pte_pkg::STATUS_TYPE2,
        pairClass ? pte_pkg::CLASS_PAIR : pte_pkg::CLASS_MULTI,
        pte_pkg::HOP_ORIGINAL};

    // learn bit low while pressed, contact bit high when closed
    logic [7:0] contactData;
    assign contactData = {4'h0, ~learnLevel, 2'h0, contactLevel};
    logic [7:0] contactStatus;
    assign contactStatus = {4'h0, pte_pkg::HOP_ORIGINAL};

    logic contactFormat;
    assign contactFormat = ctrl_reg[pte_pkg::CTRL_CONTACT_BIT];
    logic [55:0] plainFrame;
    assign plainFrame = contactFormat ?
        {pte_pkg::TYPE_CONTACT, contactData, id_reg, contactStatus} :
        {pte_pkg::TYPE_ROCKER, rockerData, id_reg, rockerStatus};

    // keystream mixes key and counter into one byte, so equal content changes with the counter but can repeat;
    // a light scrambler, not a real cipher
    logic [7:0] keyByte;
    assign keyByte = key_reg[7:0] ^ key_reg[23:16] ^ counter_reg[7:0]
        ^ {counter_reg[12:8], counter_reg[15:13]}
        ^ counter_reg[23:16] ^ counter_reg[31:24];
    logic [55:0] secureFrame;
    assign secureFrame = {pte_pkg::TYPE_SECURE, rockerData ^ keyByte,
        id_reg, rockerStatus ^ {4'h0, keyByte[7:4]}};

    // teach-in part one names a pushbutton, part two closes it
    logic [55:0] teachOneFrame;
    logic [55:0] teachTwoFrame;
    assign teachOneFrame = {pte_pkg::TYPE_TEACHIN,
        pte_pkg::PUSHBUTTON_TEACHIN_TYPE, 4'h0, id_reg,
        pte_pkg::HOP_ORIGINAL, 4'h0};
    assign teachTwoFrame = {pte_pkg::TYPE_TEACHIN,
        pte_pkg::PUSHBUTTON_TEACHIN_TYPE, 4'h1, id_reg,
        pte_pkg::HOP_ORIGINAL, 4'h0};

    // priority: unsecured strap, secure strap, owed teach-in part two,
    // secure telegram, plain telegram.
    // both straps tied together is a wiring fault; falling back to the
    // unsecured mode is the safe side, as no key material leaves then.
    // pulse decision; the unsecured strap wins over the secure strap
    pte_pkg::pte_kind_type kindNext;
    logic [55:0] frameNext;
    always_comb begin
        kindNext = pte_pkg::PTE_KIND_PLAIN;
        frameNext = plainFrame;
        if (standardStrap) begin
            kindNext = pte_pkg::PTE_KIND_PLAIN;
            frameNext = plainFrame;
        end else if (secureStrap) begin
            kindNext = pte_pkg::PTE_KIND_TEACH_ONE;
            frameNext = teachOneFrame;
        end else if (teachPending_reg) begin
            kindNext = pte_pkg::PTE_KIND_TEACH_TWO;
            frameNext = teachTwoFrame;
        end else if (mode_reg == pte_pkg::PTE_MODE_SECURE) begin
            kindNext = pte_pkg::PTE_KIND_SECURE;
            frameNext = secureFrame;
        end
    end

    // zero wait states: pready follows one cycle after setup, so every
    // access takes exactly two cycles and the bus never stalls.
    // unmapped offsets answer with pslverr and read as zero.
    // apb decode
    logic setupPhase;
    logic accessDone;
    logic wrDone;
    logic hitCtrl;
    logic hitId;
    logic hitKey;
    logic hitState;
    logic hitCounter;
    logic hitLastLo;
    logic hitLastHi;
    logic hitAny;
    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & pready;
    assign wrDone = accessDone & pwrite & ~pslverr;
    assign hitCtrl = paddr == pte_pkg::OFS_CTRL;
    assign hitId = paddr == pte_pkg::OFS_ID;
    assign hitKey = paddr == pte_pkg::OFS_KEY;
    assign hitState = paddr == pte_pkg::OFS_STATE;
    assign hitCounter = paddr == pte_pkg::OFS_COUNTER;
    assign hitLastLo = paddr == pte_pkg::OFS_LAST_LO;
    assign hitLastHi = paddr == pte_pkg::OFS_LAST_HI;
    assign hitAny = hitCtrl | hitId | hitKey | hitState | hitCounter
        | hitLastLo | hitLastHi;

    // counter seed only writable outside secure mode, so a running
    // sequence can never be rewound behind the receiver's back
    logic seedWrite;
    assign seedWrite = wrDone & hitCounter
        & (mode_reg == pte_pkg::PTE_MODE_STANDARD);

    logic [31:0] readMux;
    always_comb begin
        readMux = 32'h00000000;
        if (hitCtrl) begin
            readMux = {30'h0, ctrl_reg};
        end else if (hitId) begin
            readMux = id_reg;
        end else if (hitKey) begin
            readMux = 32'h00000000;
        end else if (hitState) begin
            readMux = {29'h0, telegramKind == pte_pkg::PTE_KIND_SECURE,
                teachPending_reg, mode_reg};
        end else if (hitCounter) begin
            readMux = counter_reg;
        end else if (hitLastLo) begin
            readMux = telegramBytes[31:0];
        end else if (hitLastHi) begin
            readMux = {8'h00, telegramBytes[55:32]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~hitAny;
            prdata <= setupPhase ? readMux : 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_reg <= pte_pkg::RST_CTRL;
            id_reg <= pte_pkg::RST_ID;
            key_reg <= pte_pkg::RST_KEY;
        end else if (wrDone) begin
            if (hitCtrl) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (hitId) begin
                id_reg <= pwdata;
            end
            if (hitKey) begin
                key_reg <= pwdata;
            end
        end
    end

    // the counter moves only on secure telegrams, never on teach-in, so
    // the value carried by teach-in is the one the next secure telegram
    // uses; a seed write that meets a pulse in the same cycle is lost.
    // mode, teach-in bookkeeping and rolling counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_reg <= pte_pkg::PTE_MODE_STANDARD;
            teachPending_reg <= 1'b0;
            counter_reg <= pte_pkg::RST_COUNTER;
        end else if (pulseEvent) begin
            if (standardStrap) begin
                mode_reg <= pte_pkg::PTE_MODE_STANDARD;
                teachPending_reg <= 1'b0;
            end else if (secureStrap) begin
                mode_reg <= pte_pkg::PTE_MODE_SECURE;
                teachPending_reg <= 1'b1;
            end else if (teachPending_reg) begin
                teachPending_reg <= 1'b0;
            end else if (mode_reg == pte_pkg::PTE_MODE_SECURE) begin
                counter_reg <= counter_reg + 32'h1;
            end
        end else if (seedWrite) begin
            counter_reg <= pwdata;
        end
    end

    // bytes, kind and counter hold until the next telegram; the strobe
    // marks the one cycle in which a new telegram is presented.
    // telegram output stage
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            telegramBytes <= 56'h0;
            telegramStrobe <= 1'b0;
            telegramKind <= pte_pkg::PTE_KIND_PLAIN;
            teachCounter <= 32'h00000000;
            secureActive <= 1'b0;
        end else begin
            telegramStrobe <= pulseEvent;
            secureActive <= mode_reg == pte_pkg::PTE_MODE_SECURE;
            if (pulseEvent) begin
                telegramBytes <= frameNext;
                telegramKind <= kindNext;
                // counter value leaves only with teach-in
                teachCounter <= (kindNext == pte_pkg::PTE_KIND_PLAIN ||
                    kindNext == pte_pkg::PTE_KIND_SECURE) ?
                    32'h00000000 : counter_reg;
            end
        end
    end

endmodule

/* File: hw/pte_pkg.sv */
// constants and types for the pushbutton telegram encoder
// What this block does
// - seven bytes: type, data, id, status
// - rocker format type byte is fixed
// - 32-bit unique id in bytes 4..1
// - status: reserved, type 2, message class
// - low status nibble holds hop count
// - one or two presses: button-pair class
// - zero, three, four presses: multi-press class
// - multi-press bits 7..5 carry press count
// - multi-press bit 4 carries pulse polarity
// - secure telegrams scrambled by rolling counter
// - counter sent only in teach-in, then increments
// - start unsecured; secure pad enters secure mode
// - secure entry sends pushbutton teach-in telegram
// - teach-in repeats while secure pad tied
// - teach-in split over two successive pulses
// - unsecured pad returns to unsecured mode
// - contact format type byte is fixed
// - contact data: learn bit 3, contact bit 0
// - contact status: only hop count meaningful
// - transmit only on energy pulse
// - sample polarity and rocker levels per pulse
package pte_pkg;

    typedef enum logic [0:0] {
        PTE_MODE_STANDARD = 1'b0,
        PTE_MODE_SECURE = 1'b1
    } pte_mode_type;

    typedef enum logic [1:0] {
        PTE_KIND_PLAIN = 2'b00,
        PTE_KIND_TEACH_ONE = 2'b01,
        PTE_KIND_TEACH_TWO = 2'b10,
        PTE_KIND_SECURE = 2'b11
    } pte_kind_type;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ID = 8'h04;
    localparam logic [7:0] OFS_KEY = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0c;
    localparam logic [7:0] OFS_COUNTER = 8'h10;
    localparam logic [7:0] OFS_LAST_LO = 8'h14;
    localparam logic [7:0] OFS_LAST_HI = 8'h18;

    // ctrl bit positions
    localparam int CTRL_CONTACT_BIT = 0;
    localparam int CTRL_PAIR_BIT = 1;

    // reset values
    localparam logic [31:0] RST_ID = 32'h00000001; // arbitrary
    localparam logic [31:0] RST_KEY = 32'h00000000;
    localparam logic [31:0] RST_COUNTER = 32'h00000000;
    localparam logic [1:0] RST_CTRL = 2'h0;

    // telegram codes
    localparam logic [7:0] TYPE_ROCKER = 8'hf6;
    localparam logic [7:0] TYPE_CONTACT = 8'hd5;
    localparam logic [7:0] TYPE_SECURE = 8'h31; // arbitrary
    localparam logic [7:0] TYPE_TEACHIN = 8'h35; // arbitrary
    localparam logic [3:0] PUSHBUTTON_TEACHIN_TYPE = 4'h1;
    localparam logic [1:0] STATUS_RESERVED = 2'h0;
    localparam logic STATUS_TYPE2 = 1'b1;
    localparam logic CLASS_MULTI = 1'b0;
    localparam logic CLASS_PAIR = 1'b1;
    localparam logic [3:0] HOP_ORIGINAL = 4'h0;
    localparam logic [2:0] COUNT_NONE = 3'h0;
    localparam logic [2:0] COUNT_THREE = 3'h3;
    localparam logic [2:0] COUNT_FOUR = 3'h4;
    localparam int SYNC_WIDTH = 9;

endpackage

/* File: dv/pte_encoder_sva.sv */
// assertions on the telegram encoder outputs
`timescale 1ns/1ns
module pte_encoder_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic harvester_input_one,
    input wire logic harvester_input_two,
    input wire logic [55:0] telegramBytes,
    input wire logic telegramStrobe,
    input wire pte_pkg::pte_kind_type telegramKind,
    input wire logic secureActive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic [7:0] ty = telegramBytes[55:48];
    wire logic [7:0] da = telegramBytes[47:40];
    wire logic [7:0] st = telegramBytes[7:0];
    wire logic pu = harvester_input_one ^ harvester_input_two;
    wire logic pl = telegramStrobe && telegramKind == pte_pkg::PTE_KIND_PLAIN;
    wire logic rk = pl && ty == pte_pkg::TYPE_ROCKER;
    wire logic tc = telegramStrobe && telegramKind inside
        {pte_pkg::PTE_KIND_TEACH_ONE, pte_pkg::PTE_KIND_TEACH_TWO};
    a_type_fixed: assert property (pl |-> ty == pte_pkg::TYPE_ROCKER ||
        ty == pte_pkg::TYPE_CONTACT) else $error("bad type byte");
    a_rocker_status: assert property (rk |-> st[7:5] == 3'b001 &&
        st[3:0] == 4'h0) else $error("bad rocker status");
    a_pair_layout: assert property (rk && st[4] |-> !da[7] && !da[3])
        else $error("bad pair data");
    a_multi_count: assert property (rk && !st[4] |-> da[3:0] == 4'h0 &&
        da[7:5] inside {3'h0, 3'h3, 3'h4}) else $error("bad multi data");
    a_contact_fields: assert property (pl && ty == pte_pkg::TYPE_CONTACT
        |-> st == 8'h00 && da[7:4] == 4'h0 && da[2:1] == 2'h0)
        else $error("bad contact frame");
    a_strobe_single: assert property (telegramStrobe |=> !telegramStrobe)
        else $error("strobe too long");
    a_pulse_cause: assert property (telegramStrobe |-> $past(pu, 3) &&
        !$past(pu, 4)) else $error("telegram without pulse");
    a_teach_frame: assert property (tc |-> ty == pte_pkg::TYPE_TEACHIN &&
        st == 8'h00 && da[7:4] == pte_pkg::PUSHBUTTON_TEACHIN_TYPE)
        else $error("bad teach frame");
    a_secure_type: assert property (telegramStrobe && telegramKind ==
        pte_pkg::PTE_KIND_SECURE |-> ty == pte_pkg::TYPE_SECURE && secureActive)
        else $error("bad secure frame");
    a_secure_entry: assert property (telegramStrobe && telegramKind ==
        pte_pkg::PTE_KIND_TEACH_ONE |-> ##[0:2] secureActive)
        else $error("secure mode not entered");
    a_bytes_hold: assert property (!telegramStrobe |-> $stable(telegramBytes))
        else $error("bytes changed without strobe");
endmodule
bind pte_encoder pte_encoder_sva u_pte_encoder_sva (.ref_clk(ref_clk),
    .rst_n(rst_n), .harvester_input_one(harvester_input_one),
    .harvester_input_two(harvester_input_two), .telegramBytes(telegramBytes),
    .telegramStrobe(telegramStrobe), .telegramKind(telegramKind),
    .secureActive(secureActive));

/* File: dv/pte_receiver_model.sv */
// radio receiver model tracking the rolling counter
`timescale 1ns/1ns
module pte_receiver_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic telegramStrobe,
    input wire pte_pkg::pte_kind_type telegramKind,
    input wire logic [31:0] teachCounter,
    output logic [31:0] rxCounter
);
    wire logic teach = telegramKind == pte_pkg::PTE_KIND_TEACH_ONE;
    wire logic sec = telegramKind == pte_pkg::PTE_KIND_SECURE;
    // no window search: every frame reaches us, so resync is teach only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxCounter <= '0;
        end else if (telegramStrobe && teach) begin
            rxCounter <= teachCounter;
        end else if (telegramStrobe && sec) begin
            rxCounter <= rxCounter + 32'h00000001;
        end
    end
endmodule

/* File: dv/pte_encoder_tb.sv */
// self-checking bench for the telegram encoder
`timescale 1ns/1ns
module pte_encoder_tb;
    typedef struct {logic [55:0] b; logic [55:0] m; logic [1:0] k;
        logic [31:0] c;} pte_note_type;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, teachCounter, rxCounter, rid, seed;
    logic hOne, hTwo, securePad, standardPad, learn, contact, p;
    logic [3:0] rock;
    logic [55:0] telegramBytes;
    logic telegramStrobe, secureActive;
    pte_pkg::pte_kind_type telegramKind;
    int bad_count, checks_done, cycles;
    pte_note_type tq[$];
    pte_note_type n;
    logic [32:0] rq[$];
    logic [55:0] sec[$];
    pte_encoder u_pte_encoder (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .harvester_input_one(hOne),
        .harvester_input_two(hTwo), .rocker_a_off_input_n(~rock[0]),
        .rocker_a_on_input_n(~rock[1]), .rocker_b_off_input_n(~rock[2]),
        .rocker_b_on_input_n(~rock[3]), .securePad(securePad),
        .standardPad(standardPad), .learnButtonPressed(learn),
        .contactClosed(contact), .telegramBytes(telegramBytes),
        .telegramStrobe(telegramStrobe), .telegramKind(telegramKind),
        .teachCounter(teachCounter), .secureActive(secureActive));
    pte_receiver_model u_pte_receiver_model (.ref_clk(ref_clk),
        .rst_n(rst_n), .telegramStrobe(telegramStrobe),
        .telegramKind(telegramKind), .teachCounter(teachCounter),
        .rxCounter(rxCounter));
    task finish_test();
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string s, input logic [63:0] e, input logic [63:0] v);
        checks_done++;
        if (v !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, v);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        if (!w)
            rq.push_back(e);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task note(input logic [7:0] t, d, s, input logic [1:0] k,
        input logic [31:0] c, input logic [55:0] m);
        tq.push_back('{{t, d, rid, s}, m, k, c});
    endtask
    // pads settle before the pulse edge, pulse held past the sync delay
    task pulse(input logic pol);
        repeat (4) @(posedge ref_clk);
        {hOne, hTwo} <= {!pol, pol};
        repeat (8) @(posedge ref_clk);
        {hOne, hTwo} <= 2'b00;
        repeat (8) @(posedge ref_clk);
    endtask
    function automatic logic [7:0] rdat(input logic [3:0] r, input logic q);
        int c;
        logic [1:0] f, s;
        c = $countones(r);
        {f, s} = 4'h0;
        for (int i = 3; i >= 0; i--)
            if (r[i]) f = 2'(i);
        for (int i = 0; i < 4; i++)
            if (r[i]) s = 2'(i);
        if (c == 1 || c == 2)
            return {1'b0, f, q, 1'b0, c == 2 ? s : 2'b00, c == 2};
        return {3'(c), q, 4'h0};
    endfunction
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("read", 64'(rq.pop_front()), 64'({pslverr, prdata}));
        if (telegramStrobe === 1'b1) begin
            n = tq.pop_front();
            chk("telegram", 64'(n.b & n.m), 64'(telegramBytes & n.m));
            chk("kind", 64'(n.k), 64'(telegramKind));
            chk("teach counter", 64'(n.c), 64'(teachCounter));
            if (telegramKind == pte_pkg::PTE_KIND_SECURE)
                sec.push_back(telegramBytes);
        end
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {hOne, hTwo, rock, securePad, standardPad, learn, contact} = '0;
        rid = pte_pkg::RST_ID;
        void'($urandom(52276));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, pte_pkg::OFS_ID, 32'h0, {1'b0, rid});
        apb(1'b0, 8'h20, 32'h0, 33'h100000000);
        rid = $urandom;
        seed = $urandom;
        apb(1'b1, pte_pkg::OFS_ID, rid, 33'h0);
        apb(1'b0, pte_pkg::OFS_ID, 32'h0, {1'b0, rid});
        apb(1'b1, pte_pkg::OFS_KEY, $urandom | 32'h1, 33'h0);
        apb(1'b0, pte_pkg::OFS_KEY, 32'h0, 33'h0);
        apb(1'b1, pte_pkg::OFS_COUNTER, seed, 33'h0);
        for (int i = 0; i < 16; i++) begin
            p = 1'($urandom);
            rock <= 4'(i);
            note(8'hf6, rdat(4'(i), p), {3'b001,
                $countones(4'(i)) inside {1, 2}, 4'h0}, 2'h0, 32'h0, '1);
            pulse(p);
        end
        apb(1'b1, pte_pkg::OFS_CTRL, 32'h1, 33'h0);
        for (int i = 0; i < 4; i++) begin
            {learn, contact} <= 2'(i);
            note(8'hd5, {4'h0, !i[1], 2'b00, i[0]}, 8'h00,
                2'h0, 32'h0, '1);
            pulse(i[0]);
        end
        apb(1'b1, pte_pkg::OFS_CTRL, 32'h0, 33'h0);
        rock <= 4'h1;
        securePad <= 1'b1;
        note(8'h35, 8'h10, 8'h00, 2'h1, seed, '1);
        pulse(1'b0);
        securePad <= 1'b0;
        note(8'h35, 8'h11, 8'h00, 2'h2, seed, '1);
        pulse(1'b1);
        apb(1'b1, pte_pkg::OFS_COUNTER, ~seed, 33'h0);
        apb(1'b0, pte_pkg::OFS_COUNTER, 32'h0, {1'b0, seed});
        repeat (2) begin
            note(8'h31, 8'h0, 8'h0, 2'h3, 32'h0, {8'hff, 48'h0});
            pulse(1'b0);
        end
        securePad <= 1'b1;
        note(8'h35, 8'h10, 8'h00, 2'h1, seed + 2, '1);
        pulse(1'b0);
        securePad <= 1'b0;
        note(8'h35, 8'h11, 8'h00, 2'h2, seed + 2, '1);
        pulse(1'b0);
        standardPad <= 1'b1;
        note(8'hf6, 8'h0, 8'h0, 2'h0, 32'h0, {8'hff, 48'h0});
        pulse(1'b0);
        standardPad <= 1'b0;
        repeat (40) @(posedge ref_clk);
        chk("pending", 64'h0, 64'(tq.size()));
        chk("secure differ", 64'h1, 64'(sec[0] !== sec[1]));
        chk("rx counter", 64'(seed + 2), 64'(rxCounter));
        finish_test();
    end
endmodule
